// ==== hdl/signal_output_source_select.sv ====
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module signal_output_source_select #(
    parameter int TEST_BUS_W = 8                          // Test bus width
) (
    input  wire logic                       clk_in,       // System clock, 50 MHz
    input  wire logic                       rst_b_in,     // Async reset, active low
    input  wire signal_output_pin_pkg::bus_req_s       bus_in,       // Register port request
    output logic [signal_output_pin_pkg::DATA_W-1:0]   rd_data_out,  // Read data, one cycle later
    input  wire logic [TEST_BUS_W-1:0]      test_bus_in,  // Internal test bus
    input  wire logic                       coder_env_in, // Transmit coder envelope
    input  wire logic                       tx_stream_in, // Serial stream to send
    input  wire logic                       rx_regen_in,  // Regenerated receiver signal
    input  wire logic                       rx_serial_in, // Received serial stream
    input  wire logic                       alt_rx_in,    // Second scheme receive
    input  wire logic                       alt_tx_in,    // Second scheme transmit
    input  wire logic                       alt_comp_in,  // Demodulator comparator, analog
    input  wire logic                       car_rx_in,    // Receive with carrier
    input  wire logic                       car_tx_in,    // Transmit with carrier
    input  wire logic                       car_raw_in,   // Unfiltered carrier rx, analog
    input  wire logic                       env_raw_in,   // Unfiltered envelope, analog
    input  wire logic                       rx_start_in,  // Receive command pulse
    input  wire logic                       rx_done_in,   // End of reception pulse
    input  wire logic                       rx_cancel_in, // Command abort pulse
    output logic                            receiving_out,       // Receiving mode
    output logic                            signal_output_pin_out,      // Pin level
    output logic                            signal_output_pin_oe_b_out  // Low: pin driven
);
    import signal_output_pin_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    localparam int TB_IDX_W = $clog2(TEST_BUS_W);        // Test bus index width

    logic [SEL_W-1:0]  output_pin_source_select;          // Pin source field
    logic [DRV_W-1:0]  driver_sel;                        // Antenna driver field, stored only
    logic [TBIT_W-1:0] test_bus_bit_choice;               // Test bus bit index
    logic              receive_repeat_bit;                // Stay receiving after reception
    rx_mode_e          rx_mode;                           // Receive mode state
    rx_mode_e          next_rx_mode;                      // Next receive mode
    logic [2:0]        analog_sync;                       // Synchronised analog levels
    src_s              src;                               // Source bundle
    logic              mux_drive;                         // Mux wants pin driven
    logic              mux_level;                         // Mux level
    logic [DATA_W-1:0] next_rd_data;                      // Read data mux
    logic [DATA_W-1:0] status;                            // Status byte
    logic [DATA_W-1:0] tx_sel_byte;                       // Select register image
    out_sel_e          sel_code;                          // Field as code

    // ****************************************
    // Analog input synchronisation
    // ****************************************
    level_sync #(
        .WIDTH    (3)
    ) u_analog_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in ({alt_comp_in, car_raw_in, env_raw_in}),
        .sync_out (analog_sync)
    );

    // ****************************************
    // Source bundle
    // ****************************************
    // Test bus bit picked by the stored choice
    always_comb begin
        src            = '0;
        src.test_bit   = test_bus_in[test_bus_bit_choice[TB_IDX_W-1:0]];
        src.coder_env  = coder_env_in;
        src.tx_stream  = tx_stream_in;
        src.rx_regen   = rx_regen_in;
        src.rx_serial  = rx_serial_in;
        src.alt_rx     = alt_rx_in;
        src.alt_tx     = alt_tx_in;
        src.alt_comp   = analog_sync[2];
        src.car_rx     = car_rx_in;
        src.car_tx     = car_tx_in;
        src.car_rx_raw = analog_sync[1];
        src.env_raw    = analog_sync[0];
    end

    assign sel_code = out_sel_e'(output_pin_source_select);

    source_mux u_mux (
        .sel_in       (sel_code),
        .src_in       (src),
        .receiving_in (receiving_out),
        .drive_out    (mux_drive),
        .level_out    (mux_level)
    );

    // ****************************************
    // Select register writes
    // ****************************************
    // Pin source and driver fields
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            output_pin_source_select <= TX_SEL_RESET[SEL_LSB +: SEL_W];
            driver_sel               <= TX_SEL_RESET[DRV_LSB +: DRV_W];
        end else if (bus_in.wr && (bus_in.addr == TX_SEL_ADDR)) begin
            output_pin_source_select <= bus_in.wdata[SEL_LSB +: SEL_W];
            driver_sel               <= bus_in.wdata[DRV_LSB +: DRV_W];
        end
    end

    // Test bus bit choice
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            test_bus_bit_choice <= '0;
        end else if (bus_in.wr && (bus_in.addr == TEST_SEL_ADDR)) begin
            test_bus_bit_choice <= bus_in.wdata[TBIT_W-1:0];
        end
    end

    // Receive repeat control
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            receive_repeat_bit <= 1'b0;
        end else if (bus_in.wr && (bus_in.addr == RX_CTRL_ADDR)) begin
            receive_repeat_bit <= bus_in.wdata[REPEAT_POS];
        end
    end

    // ****************************************
    // Receive mode tracking
    // ****************************************
    // Start wins over done and cancel in the same cycle
    always_comb begin
        next_rx_mode = rx_mode;
        unique case (rx_mode)
            RX_IDLE: begin
                if (rx_start_in) begin
                    next_rx_mode = RX_ACTIVE;
                end
            end
            RX_ACTIVE: begin
                if (rx_start_in) begin
                    next_rx_mode = RX_ACTIVE;
                end else if (rx_cancel_in) begin
                    next_rx_mode = RX_IDLE;
                end else if (rx_done_in && !receive_repeat_bit) begin
                    next_rx_mode = RX_IDLE;
                end
            end
        endcase
    end

    // Mode register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_mode <= RX_IDLE;
        end else begin
            rx_mode <= next_rx_mode;
        end
    end

    assign receiving_out = (rx_mode == RX_ACTIVE);

    // ****************************************
    // Output pin
    // ****************************************
    // Registered so a select change acts on the next edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            signal_output_pin_out      <= 1'b0;
            signal_output_pin_oe_b_out <= 1'b1;
        end else begin
            signal_output_pin_out      <= mux_drive & mux_level;
            signal_output_pin_oe_b_out <= ~mux_drive;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Images with reserved bits as zero
    always_comb begin
        tx_sel_byte                      = ZERO_BYTE;
        tx_sel_byte[SEL_LSB +: SEL_W]    = output_pin_source_select;
        tx_sel_byte[DRV_LSB +: DRV_W]    = driver_sel;
        status                           = ZERO_BYTE;
        status[ST_RX_POS]                = receiving_out;
        status[ST_LVL_POS]               = signal_output_pin_out;
        status[ST_DRV_POS]               = ~signal_output_pin_oe_b_out;
    end

    // Address decode; unmapped reads as zero
    always_comb begin
        next_rd_data = ZERO_BYTE;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                TX_SEL_ADDR: begin
                    next_rd_data = tx_sel_byte;
                end
                TEST_SEL_ADDR: begin
                    next_rd_data[TBIT_W-1:0] = test_bus_bit_choice;
                end
                RX_CTRL_ADDR: begin
                    next_rd_data[REPEAT_POS] = receive_repeat_bit;
                end
                STATUS_ADDR: begin
                    next_rd_data = status;
                end
                default: begin
                    next_rd_data = ZERO_BYTE;
                end
            endcase
        end
    end

    // Read data stands one cycle only
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= ZERO_BYTE;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Pin follows the selected source one edge later
    tristate_code_a: assert property ((sel_code == SEL_TRISTATE) |=>
        signal_output_pin_oe_b_out)
        else $error("Code 0000 did not tristate the pin");

    low_high_code_a: assert property ((sel_code inside {SEL_LOW, SEL_HIGH}) |=>
        (!signal_output_pin_oe_b_out
         && (signal_output_pin_out == ($past(sel_code) == SEL_HIGH))))
        else $error("Fixed level code drove wrong level");

    test_bus_bit_a: assert property ((sel_code == SEL_TEST_BUS) |=>
        (signal_output_pin_out == $past(test_bus_in[test_bus_bit_choice])))
        else $error("Test bus bit not on pin");

    coder_env_a: assert property ((sel_code == SEL_CODER_ENV) |=>
        (signal_output_pin_out == $past(coder_env_in)))
        else $error("Coder envelope not on pin");

    tx_stream_a: assert property ((sel_code == SEL_TX_STREAM) |=>
        (signal_output_pin_out == $past(tx_stream_in)))
        else $error("Transmit stream not on pin");

    regen_gate_a: assert property ((sel_code == SEL_RX_REGEN) |=>
        (signal_output_pin_out == ($past(rx_regen_in) && $past(receiving_out))))
        else $error("Regenerated signal wrongly gated");

    // Receive mode tracking
    repeat_hold_a: assert property ((receiving_out && rx_done_in && !rx_cancel_in
        && receive_repeat_bit) |=> receiving_out)
        else $error("Receiving mode lost with repeat set");

    done_leave_a: assert property ((receiving_out && rx_done_in && !rx_start_in
        && !receive_repeat_bit) |=> !receiving_out ##1 (!receiving_out || $past(rx_start_in)))
        else $error("Receiving mode kept after reception");

    reserved_code_a: assert property ((sel_code == SEL_RESERVED) |=>
        (signal_output_pin_oe_b_out && !signal_output_pin_out))
        else $error("Reserved code drove the pin");

    // Asynchronous sources arrive three edges late
    env_raw_a: assert property ((sel_code == SEL_ENV_RAW) [*3] |=>
        (signal_output_pin_out == $past(env_raw_in, 3)))
        else $error("Unfiltered envelope not on pin");

    car_raw_a: assert property ((sel_code == SEL_CAR_RX_RAW) [*3] |=>
        (signal_output_pin_out == $past(car_raw_in, 3)))
        else $error("Unfiltered carrier signal not on pin");

    alt_comp_a: assert property ((sel_code == SEL_ALT_COMP) [*3] |=>
        (signal_output_pin_out == $past(alt_comp_in, 3)))
        else $error("Comparator output not on pin");

    rx_gated_a: assert property (!receiving_out
        && (sel_code inside {SEL_RX_SERIAL, SEL_ALT_RX, SEL_CAR_RX})
        |=> (!signal_output_pin_oe_b_out && !signal_output_pin_out))
        else $error("Receiver code drove pin outside receiving mode");

    rx_serial_a: assert property (receiving_out && (sel_code == SEL_RX_SERIAL) |=>
        (signal_output_pin_out == $past(rx_serial_in)))
        else $error("Received stream not on pin");

    tx_carrier_a: assert property ((sel_code inside {SEL_ALT_TX, SEL_CAR_TX}) |=>
        (signal_output_pin_out == (($past(sel_code) == SEL_ALT_TX) ? $past(alt_tx_in)
            : $past(car_tx_in))))
        else $error("Transmit module signal not on pin");

    // Main scenarios reached
    regen_live_c: cover property (receiving_out && (sel_code == SEL_RX_REGEN)
        ##1 signal_output_pin_out);
    repeat_kept_c: cover property (receiving_out && rx_done_in && receive_repeat_bit
        ##1 receiving_out);
    test_bus_c: cover property ((sel_code == SEL_TEST_BUS) && (test_bus_bit_choice != 0));
    reserved_c: cover property ((sel_code == SEL_RESERVED) ##1 signal_output_pin_oe_b_out);
    cancel_c: cover property (receiving_out && rx_cancel_in ##1 !receiving_out);
endmodule : signal_output_source_select
`default_nettype wire

// ==== shared/signal_output_pin_pkg.sv ====
// What this block does
// - Select 0000 tristate, 0001 low, 0010 high
// - Select 0011 drives chosen test bus bit
// - Select 0100 drives transmit coder envelope
// - Select 0101 drives outgoing serial stream
// - Select 0110 drives regenerated receiver signal
// - Regenerated signal is three-line module data line
// - Receiver selections 0110-1000 and 1100 valid only while receiving
// - Repeat bit keeps receiving mode after reception
// - Select 0111 drives received serial stream
// - Codes 1000-1010 second scheme module signals; 1011 reserved, tristate
// - Codes 1100, 1101 first scheme carrier signals
// - Code 1110 drives unfiltered carrier receive signal
// - Code 1111 drives unfiltered receive envelope
// - Select register resets to 10h, pin tristate
`default_nettype none
package signal_output_pin_pkg;
    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int          ADDR_W        = 8;          // Register address width
    localparam int          DATA_W        = 8;          // Register data width
    localparam logic [7:0]  TX_SEL_ADDR   = 8'h16;      // Transmit source select
    localparam logic [7:0]  TEST_SEL_ADDR = 8'h30;      // Test bus bit choice
    localparam logic [7:0]  RX_CTRL_ADDR  = 8'h31;      // Receive control
    localparam logic [7:0]  STATUS_ADDR   = 8'h32;      // Status, read only
    localparam logic [7:0]  TX_SEL_RESET  = 8'h10;      // Select register reset
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;      // Idle read data
    // ****************************************
    // Field positions
    // ****************************************
    localparam int          SEL_LSB       = 0;          // Output source select
    localparam int          SEL_W         = 4;
    localparam int          DRV_LSB       = 4;          // Antenna driver select
    localparam int          DRV_W         = 2;
    localparam int          TBIT_W        = 3;          // Test bus bit choice width
    localparam int          REPEAT_POS    = 0;          // Receive repeat bit
    localparam int          ST_RX_POS     = 0;          // Status: receiving
    localparam int          ST_LVL_POS    = 1;          // Status: pin level
    localparam int          ST_DRV_POS    = 2;          // Status: pin driven
    // ****************************************
    // Output source codes
    // ****************************************
    typedef enum logic [3:0] {
        SEL_TRISTATE   = 4'h0,
        SEL_LOW        = 4'h1,
        SEL_HIGH       = 4'h2,
        SEL_TEST_BUS   = 4'h3,
        SEL_CODER_ENV  = 4'h4,
        SEL_TX_STREAM  = 4'h5,
        SEL_RX_REGEN   = 4'h6,
        SEL_RX_SERIAL  = 4'h7,
        SEL_ALT_RX     = 4'h8,
        SEL_ALT_TX     = 4'h9,
        SEL_ALT_COMP   = 4'hA,
        SEL_RESERVED   = 4'hB,
        SEL_CAR_RX     = 4'hC,
        SEL_CAR_TX     = 4'hD,
        SEL_CAR_RX_RAW = 4'hE,
        SEL_ENV_RAW    = 4'hF
    } out_sel_e;
    // Receive mode tracker states
    typedef enum logic {
        RX_IDLE   = 1'b0,
        RX_ACTIVE = 1'b1
    } rx_mode_e;
    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;
    // Internal sources for the output pin
    typedef struct packed {
        logic test_bit;
        logic coder_env;
        logic tx_stream;
        logic rx_regen;
        logic rx_serial;
        logic alt_rx;
        logic alt_tx;
        logic alt_comp;
        logic car_rx;
        logic car_tx;
        logic car_rx_raw;
        logic env_raw;
    } src_s;
endpackage : signal_output_pin_pkg
`default_nettype wire

// ==== hdl/level_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1                      // Number of levels
) (
    input  wire logic             clk_in,        // System clock
    input  wire logic             rst_b_in,      // Async reset, active low
    input  wire logic [WIDTH-1:0] async_in,      // Levels from outside domain
    output logic      [WIDTH-1:0] sync_out       // Synchronised levels
);
    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    logic [WIDTH-1:0] meta;                      // First stage, read by stage two only

    // First stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta <= '0;
        end else begin
            meta <= async_in;
        end
    end

    // Second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_out <= '0;
        end else begin
            sync_out <= meta;
        end
    end
endmodule : level_sync
`default_nettype wire

// ==== hdl/source_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
module source_mux (
    input  wire signal_output_pin_pkg::out_sel_e sel_in,       // Output source code
    input  wire signal_output_pin_pkg::src_s     src_in,       // Internal sources
    input  wire logic                 receiving_in, // Receiving mode active
    output logic                      drive_out,    // Pin is driven
    output logic                      level_out     // Level when driven
);
    import signal_output_pin_pkg::*;

    // ****************************************
    // Source selection
    // ****************************************
    // Digital receiver sources (rx_regen, rx_serial, alt_rx, car_rx) read low outside receiving mode
    always_comb begin
        drive_out = 1'b1;
        level_out = 1'b0;
        unique case (sel_in)
            SEL_TRISTATE: begin
                drive_out = 1'b0;
            end
            SEL_LOW: begin
                level_out = 1'b0;
            end
            SEL_HIGH: begin
                level_out = 1'b1;
            end
            SEL_TEST_BUS: begin
                level_out = src_in.test_bit;
            end
            SEL_CODER_ENV: begin
                level_out = src_in.coder_env;
            end
            SEL_TX_STREAM: begin
                level_out = src_in.tx_stream;
            end
            SEL_RX_REGEN: begin
                level_out = src_in.rx_regen & receiving_in;
            end
            SEL_RX_SERIAL: begin
                level_out = src_in.rx_serial & receiving_in;
            end
            SEL_ALT_RX: begin
                level_out = src_in.alt_rx & receiving_in;
            end
            SEL_ALT_TX: begin
                level_out = src_in.alt_tx;
            end
            SEL_ALT_COMP: begin
                level_out = src_in.alt_comp;
            end
            SEL_RESERVED: begin
                drive_out = 1'b0;
            end
            SEL_CAR_RX: begin
                level_out = src_in.car_rx & receiving_in;
            end
            SEL_CAR_TX: begin
                level_out = src_in.car_tx;
            end
            SEL_CAR_RX_RAW: begin
                level_out = src_in.car_rx_raw;
            end
            SEL_ENV_RAW: begin
                level_out = src_in.env_raw;
            end
        endcase
    end
endmodule : source_mux
`default_nettype wire

// ==== verif/sam_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Module on the three-line data connection
// ****************************************
module sam_partner (
    input  wire logic clk_in,     // System clock
    input  wire logic line_in,    // Resolved data line level
    output logic      sample_out  // Last bit taken from the line
);
    // Take the data line at every rising clock edge
    always_ff @(posedge clk_in) begin
        sample_out <= line_in;
    end
endmodule : sam_partner
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import signal_output_pin_pkg::*;
    // ****************************************
    // Stimulus and wires
    // ****************************************
    logic        clk_in = 1'b0;        // System clock
    logic        rst_b_in = 1'b0;      // Reset, active low
    bus_req_s    bus = '0;             // Register port request
    logic [10:0] src = '0;             // Single-bit sources
    logic [7:0]  tbus = '0;            // Test bus
    logic [2:0]  rx_p = '0;            // Start, done, cancel pulses
    logic [7:0]  rd_data;              // Read data
    logic        rcv;                  // Receiving mode
    logic        pin;                  // Pin level
    logic        oe_b;                 // Pin enable, low drives
    logic        sample;               // Bit taken by the module
    logic [31:0] rnd = 32'h0001_33FC;  // Random state
    int          rx_model = 0;         // Expected receiving mode
    int          err_total = 0;        // Mismatches
    int          num_checks = 0;       // Comparisons
    wire         line = oe_b ? 1'b0 : pin; // Pull-down when released
    // Half-period toggle, 20 ns clock
    always #10 clk_in = ~clk_in;
    signal_output_source_select #(.TEST_BUS_W(8)) signal_output_source_select_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rd_data_out(rd_data),
        .test_bus_in(tbus), .coder_env_in(src[0]), .tx_stream_in(src[1]),
        .rx_regen_in(src[2]), .rx_serial_in(src[3]), .alt_rx_in(src[4]),
        .alt_tx_in(src[5]), .alt_comp_in(src[6]), .car_rx_in(src[7]), .car_tx_in(src[8]),
        .car_raw_in(src[9]), .env_raw_in(src[10]), .rx_start_in(rx_p[0]),
        .rx_done_in(rx_p[1]), .rx_cancel_in(rx_p[2]), .receiving_out(rcv),
        .signal_output_pin_out(pin), .signal_output_pin_oe_b_out(oe_b));
    sam_partner sam_partner_inst (.clk_in(clk_in), .line_in(line), .sample_out(sample));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    // Expected pin level per source code
    function automatic logic exp_lvl(input int c, input logic [10:0] s, input logic tb,
                                     input int rx);
        case (c)
            2:       return 1'b1;
            3:       return tb;
            4, 5:    return s[c-4];
            6, 7, 8: return s[c-4] && rx != 0;
            9, 10:   return s[c-4];
            12:      return s[7] && rx != 0;
            13, 14, 15: return s[c-5];
            default: return 1'b0;
        endcase
    endfunction : exp_lvl
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic pulse(input int k);
        @(posedge clk_in);
        rx_p[k] <= 1'b1;
        @(posedge clk_in);
        rx_p <= 3'b000;
        #1;
    endtask : pulse
    // Every code with fresh random sources; no type A mode here
    task automatic run_codes();
        logic [7:0] d;
        logic [7:0] v;
        logic       e;
        for (int c = 0; c < 16; c++) begin
            rnd = lfsr_next(rnd);
            v = {2'b00, rnd[23:22], c[3:0]};
            @(posedge clk_in);
            src <= rnd[10:0];
            tbus <= rnd[18:11];
            wr(TEST_SEL_ADDR, {5'h00, rnd[21:19]});
            wr(TX_SEL_ADDR, v);
            @(posedge clk_in);
            #1 `CHK("drive", logic'(c != 0 && c != 11), ~oe_b)
            e = exp_lvl(c, rnd[10:0], rnd[11 + rnd[21:19]], rx_model);
            repeat (2) @(posedge clk_in);
            #1 `CHK("pin", e, pin)
            if (c == 6 && rx_model != 0) `CHK("sam", rnd[2], sample)
            rd(TX_SEL_ADDR, d);
            `CHK("select", v, d)
            rd(STATUS_ADDR, d);
            `CHK("status", {5'h00, logic'(c != 0 && c != 11), e, rx_model[0]}, d)
        end
    endtask : run_codes
    task automatic test_done();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        logic [7:0] d;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1 `CHK("oe_reset", 1'b1, oe_b)
        rd(TX_SEL_ADDR, d);
        `CHK("sel_reset", TX_SEL_RESET, d)
        rd(8'h7F, d);
        `CHK("unmapped", ZERO_BYTE, d)
        run_codes();
        rd(TEST_SEL_ADDR, d);
        `CHK("tsel_rd", {5'h00, rnd[21:19]}, d)
        pulse(0);
        rx_model = 1;
        `CHK("rx_start", 1'b1, rcv)
        run_codes();
        wr(RX_CTRL_ADDR, 8'h01);
        rd(RX_CTRL_ADDR, d);
        `CHK("repeat_rd", 8'h01, d)
        pulse(1);
        `CHK("rx_repeat", 1'b1, rcv)
        pulse(2);
        rx_model = 0;
        `CHK("rx_cancel", 1'b0, rcv)
        wr(RX_CTRL_ADDR, 8'h00);
        pulse(0);
        pulse(1);
        `CHK("rx_done", 1'b0, rcv)
        run_codes();
        // Reset again in mid-run, while receiving and driving
        pulse(0);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        @(posedge clk_in);
        #1 `CHK("oe_midrst", 1'b1, oe_b)
        `CHK("rx_midrst", 1'b0, rcv)
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(TX_SEL_ADDR, d);
        `CHK("sel_midrst", TX_SEL_RESET, d)
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
